// [hw/bcmc_pkg.sv]
// Purpose: shared constants and types for the charge mode control block
// Assumes: 20 MHz core clock, register writes arrive decoded from the serial port
// Notes: sense levels are in tenths of a millivolt, voltages in millivolts
package bcmc_pkg;

  // register indices
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_CTRL1 = 3'h1;
  localparam logic [2:0] IDX_FLOAT = 3'h2;
  localparam logic [2:0] IDX_CURR = 3'h4;

  // field positions
  localparam int CTRL1_INLIM_LSB = 6;
  localparam int CTRL1_WEAK_LSB = 4;
  localparam int CTRL1_TERM_EN_BIT = 3;
  localparam int CTRL1_DIS_BIT = 2;
  localparam int CTRL1_HZ_BIT = 1;
  localparam int FLOAT_CODE_LSB = 2;
  localparam int CURR_CHG_LSB = 4;
  localparam int CURR_TERM_LSB = 0;
  localparam int STATUS_STAT_LSB = 4;

  // values after reset and writable bits
  localparam logic [7:0] CTRL1_RST = 8'h38;
  localparam logic [7:0] FLOAT_RST = 8'h28;
  localparam logic [7:0] CURR_RST = 8'h00;
  localparam logic [7:0] CTRL1_WMASK = 8'hFE;
  localparam logic [7:0] FLOAT_WMASK = 8'hFC;
  localparam logic [7:0] CURR_WMASK = 8'h77;

  // float voltage mapping
  localparam logic [12:0] FLOAT_BASE_MV = 13'h0DAC;
  localparam logic [12:0] FLOAT_STEP_MV = 13'h0014;
  localparam logic [12:0] FLOAT_MAX_MV = 13'h1158;
  localparam logic [5:0] FLOAT_TOP_CODE = 6'h2F;

  // charge sense targets, tenths of a millivolt
  localparam logic [9:0] CHG_SENSE [8] = '{10'h176, 10'h1BA, 10'h1FE, 10'h242,
                                           10'h2CA, 10'h30E, 10'h396, 10'h3DA};
  // termination step per code, tenths of a millivolt
  localparam logic [8:0] TERM_STEP_G1 = 9'h022;
  localparam logic [8:0] TERM_STEP_G2 = 9'h021;

  // input current limits in mA, all ones means no limit
  localparam logic [11:0] INLIM_MA [4] = '{12'h064, 12'h1F4, 12'h320, 12'hFFF};
  localparam logic [11:0] INLIM_NONE = 12'hFFF;

  // status codes
  localparam logic [1:0] STAT_READY = 2'h0;
  localparam logic [1:0] STAT_CHARGING = 2'h1;
  localparam logic [1:0] STAT_DONE = 2'h2;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int VERIFY_TIME_MS = 500;
  localparam int VERIFY_CYCLES = VERIFY_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RAMP_TICK_US = 10;
  localparam int RAMP_TICK_CYCLES = RAMP_TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int SENSE_MOHM = 68;

  // synchronised indication positions
  localparam int IN_SHORT = 0;
  localparam int IN_RECHG = 1;
  localparam int IN_WEAK = 2;
  localparam int IN_TERM = 3;
  localparam int IN_CV = 4;
  localparam int IN_HOT = 5;
  localparam int IN_SAG = 6;
  localparam int IN_BAT = 7;
  localparam int IN_SRC = 8;
  localparam int IN_POR = 9;
  localparam int IN_COUNT = 10;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PRECHG = 6'h02,
    ST_CC = 6'h04,
    ST_CV = 6'h08,
    ST_VERIFY = 6'h10,
    ST_DONE = 6'h20
  } bcmc_state_e;

endpackage

// [hw/bcmc_ramp_if.sv]
// Purpose: carries current targets between the sequencer and the ramp
// Assumes: single clock domain
// Notes: levels are in tenths of a millivolt of sense voltage
`timescale 1ns/1ns
interface bcmc_ramp_if;
  logic run;
  logic hot;
  logic supplySag;
  logic [9:0] chargeTarget;
  logic [11:0] inputLimitMa;
  logic [9:0] appliedTarget;

  modport ctrl (output run, hot, supplySag, chargeTarget, inputLimitMa, input appliedTarget);
  modport ramp (input run, hot, supplySag, chargeTarget, inputLimitMa, output appliedTarget);
endinterface

// [hw/bcmc_sync.sv]
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous levels
// Notes: output changes only when the second and third stages agree
`timescale 1ns/1ns
module bcmc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] q;
  } bcmc_sync_s;

  bcmc_sync_s sync_reg;
  bcmc_sync_s sync_next;

  always_comb begin
    sync_next = sync_reg;
    sync_next.ff1 = d;
    sync_next.ff2 = sync_reg.ff1;
    sync_next.ff3 = sync_reg.ff2;
    // hold while the late stages disagree
    sync_next.q = (sync_reg.ff2 & sync_reg.ff3) |
                  (sync_reg.q & (sync_reg.ff2 | sync_reg.ff3));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.q;

endmodule

// [hw/bcmc_ramp.sv]
// Purpose: slew-limited charge current target with thermal and supply backoff
// Assumes: targets refreshed every cycle by the sequencer
// Notes: one step per tick upward, immediate clamp downward
`timescale 1ns/1ns
module bcmc_ramp
  import bcmc_pkg::*;
#(
  parameter int TICK_CYCLES = RAMP_TICK_CYCLES,
  parameter int MOHM = SENSE_MOHM
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // targets
  bcmc_ramp_if.ramp rif
);

  typedef struct packed {
    logic [15:0] tickCnt;
    logic [9:0] level;
  } bcmc_ramp_s;

  bcmc_ramp_s ramp_reg;
  bcmc_ramp_s ramp_next;
  logic tick;
  logic [23:0] limWide;
  logic [9:0] cap;

  always_comb begin
    ramp_next = ramp_reg;
    tick = (ramp_reg.tickCnt == 16'(TICK_CYCLES - 1));
    ramp_next.tickCnt = tick ? 16'h0000 : ramp_reg.tickCnt + 16'h0001;
    // input limit turned into sense volts so both bounds compare directly
    limWide = 24'(rif.inputLimitMa) * 24'(MOHM) / 24'h000064;
    cap = rif.chargeTarget;
    if (rif.inputLimitMa != INLIM_NONE && limWide < 24'(rif.chargeTarget)) begin
      cap = limWide[9:0];
    end
    if (!rif.run) begin
      ramp_next.level = 10'h000;
    end else if (ramp_reg.level > cap) begin
      ramp_next.level = cap;
    end else if (tick) begin
      if (rif.hot || rif.supplySag) begin
        if (ramp_reg.level != 10'h000) begin
          ramp_next.level = ramp_reg.level - 10'h001;
        end
      end else if (ramp_reg.level < cap) begin
        ramp_next.level = ramp_reg.level + 10'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ramp_reg <= '0;
    end else begin
      ramp_reg <= ramp_next;
    end
  end

  assign rif.appliedTarget = ramp_reg.level;

  property p_ramp_slew;
    @(posedge clk) disable iff (!resetn)
    $past(rif.run) && rif.run && (ramp_reg.level > $past(ramp_reg.level))
      |-> ramp_reg.level == $past(ramp_reg.level) + 10'h001;
  endproperty
  a_ramp_slew: assert property (p_ramp_slew) else $error("ramp stepped too far");

  property p_hot_backoff;
    @(posedge clk) disable iff (!resetn)
    tick && rif.run && rif.hot && ramp_reg.level != 10'h000 && ramp_reg.level <= cap
      |=> ramp_reg.level == $past(ramp_reg.level) - 10'h001;
  endproperty
  a_hot_backoff: assert property (p_hot_backoff) else $error("no thermal backoff");

  property p_sag_backoff;
    @(posedge clk) disable iff (!resetn)
    tick && rif.run && rif.supplySag && !rif.hot && ramp_reg.level != 10'h000
      && ramp_reg.level <= cap |=> ramp_reg.level < $past(ramp_reg.level);
  endproperty
  a_sag_backoff: assert property (p_sag_backoff) else $error("no supply backoff");

  property p_cap_bound;
    @(posedge clk) disable iff (!resetn)
    rif.run |=> ramp_reg.level <= $past(cap);
  endproperty
  a_cap_bound: assert property (p_cap_bound) else $error("level above limit");

endmodule

// [hw/bcmc_top.sv]
// Purpose: charge mode sequencing, parameter decode and termination check
// Assumes: register writes come decoded from the serial port, one per strobe
// Notes: analog indications are asynchronous and pass the synchroniser
`timescale 1ns/1ns

// Function
// - float code maps 3.5 V plus 20 mV per step, saturating at 4.44 V
// - fields sit at fixed bit positions in registers one, two and four
// - low-current termination only while the termination enable bit is set
// - battery below float minus recharge offset starts a new cycle
// - auto-start variants start a cycle on supply reset release with weak battery
// - host clearing disable or high-impedance bit starts a new cycle
// - charge current code selects one of eight sense voltage targets
// - termination threshold is code plus one times 3.4 or 3.3 mV
// - below termination: stop switching, report ready for about 500 ms
// - then report done only if battery and source both still present
// - precharge linearly below short threshold, then constant-current switching
// - charge current target ramps gradually upward, drops at once to a lower bound
// - die at temperature limit reduces the charge current target
// - lower of input limit and charge current bounds constant-current charging
// - supply sag to special charger voltage reduces charge current
// - input code selects 100, 500, 800 mA or no limit
module bcmc_top
  import bcmc_pkg::*;
#(
  parameter int VERIFY_CNT = VERIFY_CYCLES,
  parameter bit AUTO_START = 1'b1,
  parameter bit TERM_GROUP2 = 1'b0,
  parameter int RAMP_CNT = RAMP_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // analog indications
  input wire logic batBelowShort,
  input wire logic batBelowRecharge,
  input wire logic batBelowWeak,
  input wire logic chargeBelowTerm,
  input wire logic voltageLoopActive,
  input wire logic dieAtLimit,
  input wire logic vbusAtSpecial,
  input wire logic batteryPresent,
  input wire logic sourcePresent,
  input wire logic vbusPorClear,
  // regulation targets
  output logic [12:0] floatTargetMv,
  output logic [9:0] chargeSenseTarget,
  output logic [8:0] termSenseThreshold,
  output logic [11:0] inputLimitMa,
  // phase and status
  output logic prechargeEnable,
  output logic pwmEnable,
  output logic [1:0] statusCode,
  output logic cycleStartPulse
);

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] floatReg;
    logic [7:0] currReg;
    bcmc_state_e state;
    logic [23:0] verifyCnt;
    logic [1:0] status;
    logic [7:0] rdata;
    logic [12:0] floatMv;
    logic [9:0] chgTarget;
    logic [8:0] termTh;
    logic [11:0] inLimMa;
    logic precharge;
    logic pwm;
    logic porPrev;
    logic startPulse;
    logic [9:0] applied;
  } bcmc_core_s;

  bcmc_core_s core_reg;
  bcmc_core_s core_next;
  logic [IN_COUNT-1:0] rawIn;
  logic [IN_COUNT-1:0] syncIn;
  logic hostStart;
  logic autoStart;
  logic rechargeStart;
  logic start;
  logic inhibit;
  logic [5:0] floatCode;
  logic [2:0] termCode;
  logic [8:0] termStep;

  bcmc_ramp_if rif ();

  assign rawIn = {vbusPorClear, sourcePresent, batteryPresent, vbusAtSpecial, dieAtLimit,
                  voltageLoopActive, chargeBelowTerm, batBelowWeak, batBelowRecharge,
                  batBelowShort};

  bcmc_sync #(
    .W(IN_COUNT)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d(rawIn),
    .q(syncIn)
  );

  bcmc_ramp #(
    .TICK_CYCLES(RAMP_CNT),
    .MOHM(SENSE_MOHM)
  ) u_ramp (
    .clk(clk),
    .resetn(resetn),
    .rif(rif)
  );

  assign rif.run = core_reg.pwm;
  assign rif.hot = syncIn[IN_HOT];
  assign rif.supplySag = syncIn[IN_SAG];
  assign rif.chargeTarget = core_reg.chgTarget;
  assign rif.inputLimitMa = core_reg.inLimMa;

  always_comb begin
    core_next = core_reg;
    core_next.startPulse = 1'b0;
    core_next.porPrev = syncIn[IN_POR];
    core_next.applied = rif.appliedTarget;
    hostStart = 1'b0;
    // register writes
    if (regWrite) begin
      unique case (regAddr)
        IDX_CTRL1: begin
          core_next.ctrl1 = regWdata & CTRL1_WMASK;
          // only a one-to-zero change of either bit counts as a start
          hostStart = (core_reg.ctrl1[CTRL1_DIS_BIT] && !regWdata[CTRL1_DIS_BIT]) ||
                      (core_reg.ctrl1[CTRL1_HZ_BIT] && !regWdata[CTRL1_HZ_BIT]);
        end
        IDX_FLOAT: core_next.floatReg = regWdata & FLOAT_WMASK;
        IDX_CURR: core_next.currReg = regWdata & CURR_WMASK;
        default: ;
      endcase
    end
    inhibit = core_next.ctrl1[CTRL1_DIS_BIT] || core_next.ctrl1[CTRL1_HZ_BIT];
    autoStart = AUTO_START && syncIn[IN_POR] && !core_reg.porPrev && syncIn[IN_WEAK];
    rechargeStart = (core_reg.state == ST_DONE) && syncIn[IN_RECHG];
    start = !inhibit && (hostStart || autoStart || rechargeStart);
    // sequencer
    if (inhibit) begin
      core_next.state = ST_IDLE;
    end else if (start) begin
      core_next.state = syncIn[IN_SHORT] ? ST_PRECHG : ST_CC;
      core_next.startPulse = 1'b1;
    end else begin
      unique case (core_reg.state)
        ST_IDLE: ;
        ST_DONE: ;
        ST_PRECHG: begin
          if (!syncIn[IN_SHORT]) begin
            core_next.state = ST_CC;
          end
        end
        ST_CC: begin
          if (syncIn[IN_CV]) begin
            core_next.state = ST_CV;
          end
        end
        ST_CV: begin
          if (core_next.ctrl1[CTRL1_TERM_EN_BIT] && syncIn[IN_TERM]) begin
            core_next.state = ST_VERIFY;
            core_next.verifyCnt = 24'h000000;
          end
        end
        ST_VERIFY: begin
          core_next.verifyCnt = core_reg.verifyCnt + 24'h000001;
          if (core_reg.verifyCnt == 24'(VERIFY_CNT - 1)) begin
            // presence is sampled only at expiry
            core_next.state = (syncIn[IN_BAT] && syncIn[IN_SRC]) ? ST_DONE : ST_IDLE;
          end
        end
        default: core_next.state = ST_IDLE;
      endcase
    end
    // phase and status follow the next state so they stay aligned with it
    core_next.precharge = (core_next.state == ST_PRECHG);
    core_next.pwm = (core_next.state == ST_CC) || (core_next.state == ST_CV);
    if (core_next.state == ST_DONE) begin
      core_next.status = STAT_DONE;
    end else if (core_next.precharge || core_next.pwm) begin
      core_next.status = STAT_CHARGING;
    end else begin
      core_next.status = STAT_READY;
    end
    // decode of programmed fields
    floatCode = core_next.floatReg[FLOAT_CODE_LSB +: 6];
    if (floatCode > FLOAT_TOP_CODE) begin
      core_next.floatMv = FLOAT_MAX_MV;
    end else begin
      core_next.floatMv = FLOAT_BASE_MV + 13'(floatCode) * FLOAT_STEP_MV;
    end
    core_next.chgTarget = CHG_SENSE[core_next.currReg[CURR_CHG_LSB +: 3]];
    termCode = core_next.currReg[CURR_TERM_LSB +: 3];
    termStep = TERM_GROUP2 ? TERM_STEP_G2 : TERM_STEP_G1;
    core_next.termTh = 9'((9'(termCode) + 9'h001) * termStep);
    core_next.inLimMa = INLIM_MA[core_next.ctrl1[CTRL1_INLIM_LSB +: 2]];
    // readback
    if (regRead) begin
      core_next.rdata = 8'h00;
      unique case (regAddr)
        IDX_STATUS: core_next.rdata[STATUS_STAT_LSB +: 2] = core_reg.status;
        IDX_CTRL1: core_next.rdata = core_reg.ctrl1;
        IDX_FLOAT: core_next.rdata = core_reg.floatReg;
        IDX_CURR: core_next.rdata = core_reg.currReg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_reg <= '0;
      core_reg.ctrl1 <= CTRL1_RST;
      core_reg.floatReg <= FLOAT_RST;
      core_reg.currReg <= CURR_RST;
      core_reg.state <= ST_IDLE;
      core_reg.status <= STAT_READY;
    end else begin
      core_reg <= core_next;
    end
  end

  assign regRdata = core_reg.rdata;
  assign floatTargetMv = core_reg.floatMv;
  assign chargeSenseTarget = core_reg.applied;
  assign termSenseThreshold = core_reg.termTh;
  assign inputLimitMa = core_reg.inLimMa;
  assign prechargeEnable = core_reg.precharge;
  assign pwmEnable = core_reg.pwm;
  assign statusCode = core_reg.status;
  assign cycleStartPulse = core_reg.startPulse;

  // decoded outputs read zero until the first edge after reset release
  property p_float_map;
    @(posedge clk) disable iff (!resetn)
    $past(resetn) |-> floatTargetMv == ((core_reg.floatReg[7:2] > 6'h2F) ? 13'h1158 :
                      13'h0DAC + 13'(core_reg.floatReg[7:2]) * 13'h0014);
  endproperty
  a_float_map: assert property (p_float_map) else $error("float target wrong");

  property p_chg_table;
    @(posedge clk) disable iff (!resetn)
    (core_reg.currReg[6:4] == 3'h4 |-> core_reg.chgTarget == 10'h2CA) and
    (core_reg.currReg[6:4] == 3'h7 |-> core_reg.chgTarget == 10'h3DA);
  endproperty
  a_chg_table: assert property (p_chg_table) else $error("charge target wrong");

  property p_term_th;
    @(posedge clk) disable iff (!resetn)
    $past(resetn) |-> termSenseThreshold == 9'((9'(core_reg.currReg[2:0]) + 9'h001) *
                             (TERM_GROUP2 ? 9'h021 : 9'h022));
  endproperty
  a_term_th: assert property (p_term_th) else $error("termination threshold wrong");

  property p_term_en_gate;
    @(posedge clk) disable iff (!resetn)
    core_reg.state == ST_CV && !core_reg.ctrl1[3] && !(regWrite && regAddr == IDX_CTRL1)
      |=> core_reg.state != ST_VERIFY;
  endproperty
  a_term_en_gate: assert property (p_term_en_gate) else $error("terminated while disabled");

  property p_verify_ready;
    @(posedge clk) disable iff (!resetn)
    core_reg.state == ST_VERIFY |-> statusCode == STAT_READY && !pwmEnable;
  endproperty
  a_verify_ready: assert property (p_verify_ready) else $error("verify not ready");

  property p_done_presence;
    @(posedge clk) disable iff (!resetn)
    core_reg.state == ST_DONE && $past(core_reg.state) == ST_VERIFY
      |-> $past(syncIn[IN_BAT]) && $past(syncIn[IN_SRC]) && statusCode == STAT_DONE;
  endproperty
  a_done_presence: assert property (p_done_presence) else $error("done without presence");

  property p_verify_len;
    @(posedge clk) disable iff (!resetn)
    $past(core_reg.state) == ST_VERIFY && core_reg.state != ST_VERIFY
      && !$past(inhibit) && !$past(start) |-> $past(core_reg.verifyCnt) == 24'(VERIFY_CNT - 1);
  endproperty
  a_verify_len: assert property (p_verify_len) else $error("verify interval wrong");

  property p_precharge;
    @(posedge clk) disable iff (!resetn)
    core_reg.state == ST_PRECHG && !syncIn[IN_SHORT] && !inhibit && !start
      |=> core_reg.state == ST_CC && pwmEnable && !prechargeEnable;
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge exit wrong");

  property p_host_start;
    @(posedge clk) disable iff (!resetn)
    hostStart && !inhibit |=> cycleStartPulse;
  endproperty
  a_host_start: assert property (p_host_start) else $error("host start missed");

  property p_recharge;
    @(posedge clk) disable iff (!resetn)
    core_reg.state == ST_DONE && syncIn[IN_RECHG] && !inhibit
      |=> cycleStartPulse && statusCode == STAT_CHARGING;
  endproperty
  a_recharge: assert property (p_recharge) else $error("recharge missed");

  property p_auto_start;
    @(posedge clk) disable iff (!resetn)
    autoStart && !inhibit |=> cycleStartPulse;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("auto start missed");

  property p_inlim;
    @(posedge clk) disable iff (!resetn)
    (core_reg.ctrl1[7:6] == 2'h2 |-> inputLimitMa == 12'h320) and
    (core_reg.ctrl1[7:6] == 2'h3 |-> inputLimitMa == 12'hFFF);
  endproperty
  a_inlim: assert property (p_inlim) else $error("input limit wrong");

endmodule

// [verif/bcmc_host.sv]
// Purpose: host model issuing decoded register writes and reads
// Assumes: one strobe pulse per access, driven 1 ns after the rising edge
// Notes: idle data lines show the inverse of the last value
`timescale 1ns/1ns
module bcmc_host (
  // clock
  input wire logic clk,
  // register port
  output logic regWrite,
  output logic regRead,
  output logic [2:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 3'h0;
    regWdata = 8'h00;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(posedge clk);
    #1;
    regWrite = 1'b0;
    // stale data must not look valid
    regWdata = ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    regRead = 1'b1;
    regAddr = a;
    @(posedge clk);
    #1;
    regRead = 1'b0;
    @(posedge clk);
    #1;
    d = regRdata;
  endtask
endmodule

// [verif/bcmc_top_tb_top.sv]
// Purpose: self-checking bench for charge mode control
// Assumes: short verify and ramp counts set through parameters
// Notes: analog indications are driven as plain levels
`timescale 1ns/1ns
module bcmc_top_tb_top;
  import bcmc_pkg::*;
  localparam int VCNT = 20;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic regWrite, regRead;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata, rdv;
  logic batBelowShort = 1'b0, batBelowRecharge = 1'b0, batBelowWeak = 1'b0;
  logic chargeBelowTerm = 1'b0, voltageLoopActive = 1'b0, dieAtLimit = 1'b0;
  logic vbusAtSpecial = 1'b0, batteryPresent = 1'b1, sourcePresent = 1'b1;
  logic vbusPorClear = 1'b0;
  logic [12:0] floatTargetMv, v;
  logic [9:0] chargeSenseTarget;
  logic [8:0] termSenseThreshold;
  logic [11:0] inputLimitMa;
  logic prechargeEnable, pwmEnable, cycleStartPulse;
  logic [1:0] statusCode;
  int checks = 0, failCount = 0, starts = 0, s;
  logic [8:0] termAlt;
  logic startAlt;
  int startsAlt = 0, sa;
  always #25 clk = ~clk;
  always @(posedge clk) if (cycleStartPulse === 1'b1) starts++;
  always @(posedge clk) if (startAlt === 1'b1) startsAlt++;
  bcmc_top #(.VERIFY_CNT(VCNT), .AUTO_START(1'b1), .TERM_GROUP2(1'b0), .RAMP_CNT(4)) u_bcmc_top (
    .clk(clk), .resetn(resetn), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .batBelowShort(batBelowShort),
    .batBelowRecharge(batBelowRecharge), .batBelowWeak(batBelowWeak),
    .chargeBelowTerm(chargeBelowTerm), .voltageLoopActive(voltageLoopActive),
    .dieAtLimit(dieAtLimit), .vbusAtSpecial(vbusAtSpecial), .batteryPresent(batteryPresent),
    .sourcePresent(sourcePresent), .vbusPorClear(vbusPorClear),
    .floatTargetMv(floatTargetMv), .chargeSenseTarget(chargeSenseTarget),
    .termSenseThreshold(termSenseThreshold), .inputLimitMa(inputLimitMa),
    .prechargeEnable(prechargeEnable), .pwmEnable(pwmEnable), .statusCode(statusCode),
    .cycleStartPulse(cycleStartPulse));
  bcmc_host u_bcmc_host (.clk(clk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
  // second variant: no auto start, 3.3 mV termination steps
  bcmc_top #(.VERIFY_CNT(VCNT), .AUTO_START(1'b0), .TERM_GROUP2(1'b1), .RAMP_CNT(4))
    u_bcmc_top2 (
    .clk(clk), .resetn(resetn), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(), .batBelowShort(batBelowShort),
    .batBelowRecharge(batBelowRecharge), .batBelowWeak(batBelowWeak),
    .chargeBelowTerm(chargeBelowTerm), .voltageLoopActive(voltageLoopActive),
    .dieAtLimit(dieAtLimit), .vbusAtSpecial(vbusAtSpecial), .batteryPresent(batteryPresent),
    .sourcePresent(sourcePresent), .vbusPorClear(vbusPorClear), .floatTargetMv(),
    .chargeSenseTarget(), .termSenseThreshold(termAlt), .inputLimitMa(), .prechargeEnable(),
    .pwmEnable(), .statusCode(), .cycleStartPulse(startAlt));
  task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_reset;
    logic [2:0] a [4] = '{IDX_CTRL1, IDX_FLOAT, IDX_CURR, 3'h3};
    logic [7:0] e [4] = '{8'h38, 8'h28, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++) begin
      u_bcmc_host.rd(a[i], rdv);
      chk("reset reg", 13'(rdv), 13'(e[i]));
    end
    chk("float", floatTargetMv, 13'h0E74);
    chk("term", 13'(termSenseThreshold), 13'h0022);
    chk("inlim", 13'(inputLimitMa), 13'h0064);
  endtask
  task automatic t_float;
    logic [5:0] c [4] = '{6'h00, 6'h01, 6'h2F, 6'h3F};
    logic [12:0] e [4] = '{13'h0DAC, 13'h0DC0, 13'h1158, 13'h1158};
    for (int i = 0; i < 4; i++) begin
      u_bcmc_host.wr(IDX_FLOAT, {c[i], 2'h3});
      u_bcmc_host.rd(IDX_FLOAT, rdv);
      chk("float reg", 13'(rdv), 13'({c[i], 2'h0}));
      chk("float mv", floatTargetMv, e[i]);
    end
  endtask
  task automatic t_codes;
    logic [11:0] e [4] = '{12'h064, 12'h1F4, 12'h320, 12'hFFF};
    for (int c = 0; c < 8; c++) begin
      u_bcmc_host.wr(IDX_CURR, {1'b1, 3'(c), 1'b1, 3'(c)});
      u_bcmc_host.rd(IDX_CURR, rdv);
      chk("curr reg", 13'(rdv), 13'({1'b0, 3'(c), 1'b0, 3'(c)}));
      chk("term", 13'(termSenseThreshold), 13'((c + 1) * 34));
      chk("term alt", 13'(termAlt), 13'((c + 1) * 33));
    end
    for (int i = 3; i >= 0; i--) begin
      u_bcmc_host.wr(IDX_CTRL1, {2'(i), 6'h38});
      cyc(1);
      chk("inlim", 13'(inputLimitMa), 13'(e[i]));
    end
    u_bcmc_host.wr(IDX_CURR, 8'h00);
  endtask
  task automatic t_charge;
    u_bcmc_host.wr(IDX_CTRL1, 8'h3C);
    batBelowShort = 1'b1;
    cyc(8);
    s = starts;
    u_bcmc_host.wr(IDX_CTRL1, 8'h38);
    cyc(8);
    chk("start", 13'(starts - s), 13'h0001);
    chk("pre", 13'({prechargeEnable, pwmEnable, statusCode}), 13'h0009);
    batBelowShort = 1'b0;
    cyc(8);
    chk("pwm", 13'({prechargeEnable, pwmEnable}), 13'h0001);
    // 100 mA through 68 mOhm caps the sense target at 6.8 mV
    cyc(300);
    chk("cap", 13'(chargeSenseTarget), 13'h0044);
    u_bcmc_host.wr(IDX_CTRL1, 8'hF0);
    cyc(10);
    chk("slew", 13'(chargeSenseTarget < 10'h050), 13'h0001);
    cyc(1300);
    chk("cc", 13'(chargeSenseTarget), 13'h0176);
  endtask
  task automatic t_term;
    voltageLoopActive = 1'b1;
    chargeBelowTerm = 1'b1;
    cyc(VCNT + 20);
    chk("no term", 13'({pwmEnable, statusCode}), 13'h0005);
    u_bcmc_host.wr(IDX_CTRL1, 8'hF8);
    cyc(8);
    chk("ready", 13'({pwmEnable, statusCode}), 13'h0000);
    cyc(VCNT - 9);
    chk("verify end", 13'(statusCode), 13'(STAT_READY));
    cyc(1);
    chk("done", 13'(statusCode), 13'(STAT_DONE));
    u_bcmc_host.rd(IDX_STATUS, rdv);
    chk("stat reg", 13'(rdv), 13'h0020);
    chargeBelowTerm = 1'b0;
    voltageLoopActive = 1'b0;
    s = starts;
    batBelowRecharge = 1'b1;
    cyc(8);
    chk("rechg", 13'({starts - s, statusCode}), 13'h0005);
    batBelowRecharge = 1'b0;
    sourcePresent = 1'b0;
    voltageLoopActive = 1'b1;
    chargeBelowTerm = 1'b1;
    cyc(VCNT + 20);
    chk("no src", 13'(statusCode), 13'(STAT_READY));
  endtask
  task automatic t_hot;
    sourcePresent = 1'b1;
    voltageLoopActive = 1'b0;
    chargeBelowTerm = 1'b0;
    u_bcmc_host.wr(IDX_CTRL1, 8'hFA);
    u_bcmc_host.wr(IDX_CTRL1, 8'hF8);
    cyc(1600);
    dieAtLimit = 1'b1;
    cyc(48);
    chk("hot", 13'(chargeSenseTarget < 10'h176), 13'h0001);
    dieAtLimit = 1'b0;
    vbusAtSpecial = 1'b1;
    // let the thermal backoff end before the baseline is taken
    cyc(8);
    v = 13'(chargeSenseTarget);
    cyc(40);
    chk("sag", 13'(13'(chargeSenseTarget) < v), 13'h0001);
    vbusAtSpecial = 1'b0;
    batBelowWeak = 1'b1;
    s = starts;
    sa = startsAlt;
    vbusPorClear = 1'b1;
    cyc(8);
    chk("por", 13'(starts - s), 13'h0001);
    chk("no auto", 13'(startsAlt - sa), 13'h0000);
  endtask
  initial begin
    cyc(8);
    resetn = 1'b1;
    cyc(2);
    t_reset();
    t_float();
    t_codes();
    t_charge();
    t_term();
    t_hot();
    close_out();
  end
  // the run needs about 3600 cycles
  initial begin
    #(50 * 40000);
    failCount++;
    close_out();
  end
endmodule
